// ==== rtl/rcm_pkg.sv ====
// Package for the timekeeper compare and error measurement block.
// Assumes an AXI4-Lite master on a 40 MHz aclk; offsets are byte addresses.
package rcm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL1   = 8'h00; // Counter 1 control
   localparam logic [7:0] OFF_CTRL2   = 8'h04; // Counter 2 control
   localparam logic [7:0] OFF_STATUS  = 8'h08; // Live status
   localparam logic [7:0] OFF_CMP     = 8'h0c; // Second-match compare (pending stage)
   localparam logic [7:0] OFF_MON1    = 8'h10; // Counter 1 monitor
   localparam logic [7:0] OFF_MON2    = 8'h14; // Counter 2 monitor
   localparam logic [7:0] OFF_SECONDS = 8'h18; // Seconds counter
   localparam logic [7:0] OFF_IRQ_ST  = 8'h1c; // Sticky event status
   localparam logic [7:0] OFF_IRQ_EN  = 8'h20; // Event enable
   localparam logic [7:0] OFF_IRQ_CLR = 8'h24; // Event clear, write-only
   localparam logic [7:0] OFF_ACTIVE  = 8'h28; // Active compare stage
   // Control 1 fields
   localparam int C1_ENABLE  = 0;
   localparam int C1_MEASURE = 1;
   localparam int C1_SRC     = 2; // 1: high-frequency source, 0: low-frequency
   // Control 2 fields
   localparam int C2_ENABLE  = 0;
   localparam int C2_MEASURE = 1;
   localparam int C2_REFSEL  = 2; // 0: external reference pin, 1: counter 1 tick
   localparam int C2_WIN_LO  = 3;
   localparam int C2_RESET   = 5; // Write 1: clear counters when both stopped
   // Status fields
   localparam int S_RUN1 = 0;
   localparam int S_RUN2 = 1;
   localparam int S_RDY1 = 2;
   localparam int S_RDY2 = 3;
   // Event bits
   localparam int EV_SECOND = 0;
   localparam int EV_DONE1  = 1;
   localparam int EV_DONE2  = 2;
   localparam int EV_W      = 3;
   // Widths and reset values
   localparam int CNT_W = 20;
   localparam logic [19:0] CMP_RESET = 20'hfffff;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Measurement window states
   typedef enum logic [1:0] {RCM_IDLE, RCM_ARMED, RCM_OPEN, RCM_DONE} rcm_win_e;
endpackage : rcm_pkg

// ==== rtl/rcm_top.sv ====
// Timekeeper second-match compare and error measurement block.
// Assumes one-cycle source clock enables from dividers on aclk, and an
// asynchronous reference pulse pin that is synchronised here.
`timescale 1ns/1ps
module rcm_top #(
   parameter int HF_DIV = 40,   // aclk cycles per high-frequency source clock
   parameter int LF_DIV = 1221  // aclk cycles per low-frequency source clock
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   reference_pulse_in,
   output logic                        irq
);
   import rcm_pkg::*;

   // Source clock dividers
   logic [15:0]      hf_div_reg;   // High-frequency divider
   logic [15:0]      lf_div_reg;   // Low-frequency divider
   wire              hf_tick = (hf_div_reg == 16'(HF_DIV - 1));
   wire              lf_tick = (lf_div_reg == 16'(LF_DIV - 1));

   // Registers
   logic [2:0]       ctrl1_reg;       // Counter 1 control
   logic [5:0]       ctrl2_reg;       // Counter 2 control, bit 5 one-shot reset
   logic [CNT_W-1:0] cmp_pend_reg;    // Written stage
   logic [CNT_W-1:0] cmp_act_reg;     // Active stage
   logic [CNT_W-1:0] cnt1_reg;        // Counter 1
   logic [CNT_W-1:0] cnt2_reg;        // Counter 2
   logic [7:0]       seconds_reg;     // Seconds counter
   logic             run1_reg;        // Counter 1 running flag
   logic             run2_reg;        // Counter 2 running flag
   logic [EV_W-1:0]  ev_reg;          // Sticky events
   logic [EV_W-1:0]  ev_en_reg;       // Event enables
   rcm_win_e         win1_reg;        // Counter 1 window state
   rcm_win_e         win2_reg;        // Counter 2 window state
   logic [3:0]       wcnt1_reg;       // Counter 1 window edge count
   logic [3:0]       wcnt2_reg;       // Counter 2 window edge count
   logic [2:0]       ref_sync_reg;    // Reference pin synchroniser
   logic             ref_lvl_reg;     // Filtered reference level
   logic             tick1_lvl_reg;   // Counter 1 second output level

   // Reference pin: third and second stage must agree before level changes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_sync_reg <= 3'h0;
         ref_lvl_reg  <= 1'b0;
      end else begin
         ref_sync_reg <= {ref_sync_reg[1:0], reference_pulse_in};
         if (ref_sync_reg[2] == ref_sync_reg[1])
            ref_lvl_reg <= ref_sync_reg[2];
      end
   end

   // Dividers free-run so source enables are regular
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hf_div_reg <= 16'h0;
         lf_div_reg <= 16'h0;
      end else begin
         hf_div_reg <= hf_tick ? 16'h0 : hf_div_reg + 16'h1;
         lf_div_reg <= lf_tick ? 16'h0 : lf_div_reg + 16'h1;
      end
   end

   // Window width in reference periods: 00 pulse high time, 01 one, 10 four, 11 sixteen
   function automatic logic [3:0] rcm_win_len(input logic [1:0] sel);
      rcm_win_len = (sel == 2'b11) ? 4'hf : (sel == 2'b10) ? 4'h3 : 4'h0;
   endfunction : rcm_win_len

   // AXI write channel
   wire              aw_held = !s_axi_awready; // Address taken, ready flop low while held
   logic [7:0]       aw_addr_reg;
   wire              w_held  = !s_axi_wready;  // Data taken, ready flop low while held
   logic [31:0]      w_data_reg;
   logic [3:0]       w_strb_reg;
   wire              wr_go   = aw_held && w_held && !s_axi_bvalid;
   wire              wr_ctl1 = wr_go && (aw_addr_reg == OFF_CTRL1);
   wire              wr_ctl2 = wr_go && (aw_addr_reg == OFF_CTRL2);
   wire              wr_cmp  = wr_go && (aw_addr_reg == OFF_CMP);
   wire              wr_en   = wr_go && (aw_addr_reg == OFF_IRQ_EN);
   wire              wr_clr  = wr_go && (aw_addr_reg == OFF_IRQ_CLR);
   wire              wr_ok   = wr_ctl1 || wr_ctl2 || wr_cmp || wr_en || wr_clr;

   // Counter 1 source enable and match
   wire              src1    = ctrl1_reg[C1_SRC] ? hf_tick : lf_tick;
   wire              clk_mode1 = run1_reg && !ctrl1_reg[C1_MEASURE];
   wire              match1  = clk_mode1 && src1 && (cnt1_reg + 20'h1 == cmp_act_reg); // Last tick of a second
   wire              tk_stop = !run1_reg; // Timekeeper not running

   // Window sources
   wire              win_src2 = ctrl2_reg[C2_REFSEL] ? tick1_lvl_reg : ref_lvl_reg;
   logic             win_src2_d;
   logic             ref_lvl_d;
   wire              rise1 = ref_lvl_reg && !ref_lvl_d;
   wire              rise2 = win_src2 && !win_src2_d;

   // Compare pending stage, per byte lane
   logic [CNT_W-1:0] cmp_pend_next;
   always_comb begin
      cmp_pend_next = cmp_pend_reg;
      if (wr_cmp) begin
         if (w_strb_reg[0]) cmp_pend_next[7:0]   = w_data_reg[7:0];
         if (w_strb_reg[1]) cmp_pend_next[15:8]  = w_data_reg[15:8];
         if (w_strb_reg[2]) cmp_pend_next[19:16] = w_data_reg[19:16];
      end
   end

   // Compare stages: pending moves to active on match or when stopped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_pend_reg <= CMP_RESET;
         cmp_act_reg  <= CMP_RESET;
      end else begin
         cmp_pend_reg <= cmp_pend_next;
         if (tk_stop)
            cmp_act_reg <= cmp_pend_next;
         else if (match1)
            cmp_act_reg <= cmp_pend_reg;  // old bytes stay where unwritten
      end
   end

   // Counter 1: clock mode wraps at match, measure mode counts inside window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt1_reg      <= '0;
         seconds_reg   <= 8'h0;
         tick1_lvl_reg <= 1'b0;
      end else begin
         if (ctrl2_reg[C2_RESET] && !run1_reg && !run2_reg)
            cnt1_reg <= '0;
         else if (match1)
            cnt1_reg <= '0;
         else if (run1_reg && src1 && (clk_mode1 || win1_reg == RCM_OPEN))
            cnt1_reg <= cnt1_reg + 20'h1;
         if (match1)
            seconds_reg <= seconds_reg + 8'h1;
         // 1 Hz output: rises at each match, falls at half count
         if (match1)
            tick1_lvl_reg <= 1'b1;
         else if (clk_mode1 && src1 && cnt1_reg == (cmp_act_reg >> 1))
            tick1_lvl_reg <= 1'b0;
      end
   end

   // Counter 2 always runs on the low-frequency source
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cnt2_reg <= '0;
      else if (ctrl2_reg[C2_RESET] && !run1_reg && !run2_reg)
         cnt2_reg <= '0;
      else if (run2_reg && lf_tick && (!ctrl2_reg[C2_MEASURE] || win2_reg == RCM_OPEN))
         cnt2_reg <= cnt2_reg + 20'h1;
   end

   // Window machines; an edge skew of one source clock each side is accepted
   // since window edges are not aligned to the source enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win1_reg <= RCM_IDLE;
         win2_reg <= RCM_IDLE;
         wcnt1_reg <= 4'h0;
         wcnt2_reg <= 4'h0;
         ref_lvl_d <= 1'b0;
         win_src2_d <= 1'b0;
      end else begin
         ref_lvl_d  <= ref_lvl_reg;
         win_src2_d <= win_src2;
         case (win1_reg)
            RCM_IDLE:  if (run1_reg && ctrl1_reg[C1_MEASURE]) win1_reg <= RCM_ARMED;
            RCM_ARMED: if (rise1) begin
               win1_reg  <= RCM_OPEN;
               wcnt1_reg <= rcm_win_len(ctrl2_reg[C2_WIN_LO+:2]);
            end
            RCM_OPEN:  if (rise1) begin
               if (wcnt1_reg == 4'h0) win1_reg <= RCM_DONE;
               else wcnt1_reg <= wcnt1_reg - 4'h1;
            end else if (!ref_lvl_reg && ctrl2_reg[C2_WIN_LO+:2] == 2'b00 && ref_lvl_d)
               win1_reg <= RCM_DONE;
            default:   if (!ctrl1_reg[C1_ENABLE]) win1_reg <= RCM_IDLE;
         endcase
         case (win2_reg)
            RCM_IDLE:  if (run2_reg && ctrl2_reg[C2_MEASURE]) win2_reg <= RCM_ARMED;
            RCM_ARMED: if (rise2) begin
               win2_reg  <= RCM_OPEN;
               wcnt2_reg <= rcm_win_len(ctrl2_reg[C2_WIN_LO+:2]);
            end
            RCM_OPEN:  if (rise2) begin
               if (wcnt2_reg == 4'h0) win2_reg <= RCM_DONE;
               else wcnt2_reg <= wcnt2_reg - 4'h1;
            end else if (!win_src2 && ctrl2_reg[C2_WIN_LO+:2] == 2'b00 && win_src2_d)
               win2_reg <= RCM_DONE;
            default:   if (!ctrl2_reg[C2_ENABLE]) win2_reg <= RCM_IDLE;
         endcase
      end
   end

   // Running flags follow enables, drop when a window closes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run1_reg <= 1'b0;
         run2_reg <= 1'b0;
      end else begin
         run1_reg <= ctrl1_reg[C1_ENABLE] && (win1_reg != RCM_DONE);
         run2_reg <= ctrl2_reg[C2_ENABLE] && (win2_reg != RCM_DONE);
      end
   end

   // Sticky events; a set in the clear cycle wins
   wire [EV_W-1:0] ev_set = {run2_reg && win2_reg == RCM_DONE,
                             run1_reg && win1_reg == RCM_DONE, match1};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_reg    <= '0;
         ev_en_reg <= '0;
         irq       <= 1'b0;
      end else begin
         ev_reg <= (ev_reg & ~(wr_clr ? w_data_reg[EV_W-1:0] : '0)) | ev_set;
         if (wr_en) ev_en_reg <= w_data_reg[EV_W-1:0];
         irq <= |(ev_reg & ev_en_reg);
      end
   end

   // Control registers and AXI write handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl1_reg <= 3'h0;
         ctrl2_reg <= 6'h0;
         s_axi_awready <= 1'b1; // Ready flops keep the bus outputs registered
         s_axi_wready  <= 1'b1;
         aw_addr_reg <= 8'h0;
         w_data_reg  <= 32'h0;
         w_strb_reg  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         ctrl2_reg[C2_RESET] <= 1'b0; // Counter reset is a one-shot
         if (wr_go) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (wr_ctl1 && w_strb_reg[0]) ctrl1_reg <= w_data_reg[2:0];
            if (wr_ctl2 && w_strb_reg[0]) ctrl2_reg <= w_data_reg[5:0];
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode
   wire [31:0] status_w = {28'h0, win2_reg == RCM_ARMED, win1_reg == RCM_ARMED, run2_reg, run1_reg};
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      if (s_axi_araddr == OFF_CTRL1)        rd_mux = {29'h0, ctrl1_reg};
      else if (s_axi_araddr == OFF_CTRL2)   rd_mux = {27'h0, ctrl2_reg[4:0]}; // Reset bit reads zero
      else if (s_axi_araddr == OFF_STATUS)  rd_mux = status_w;
      else if (s_axi_araddr == OFF_CMP)     rd_mux = {12'h0, cmp_pend_reg};
      else if (s_axi_araddr == OFF_MON1)    rd_mux = {12'h0, cnt1_reg};
      else if (s_axi_araddr == OFF_MON2)    rd_mux = {12'h0, cnt2_reg};
      else if (s_axi_araddr == OFF_SECONDS) rd_mux = {24'h0, seconds_reg};
      else if (s_axi_araddr == OFF_IRQ_ST)  rd_mux = {29'h0, ev_reg};
      else if (s_axi_araddr == OFF_IRQ_EN)  rd_mux = {29'h0, ev_en_reg};
      else if (s_axi_araddr == OFF_ACTIVE)  rd_mux = {12'h0, cmp_act_reg};
      else begin
         rd_mux = 32'h0;
         rd_hit = 1'b0;
      end
   end

   // Read channel: one-cycle answer after address taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0; // One read at a time
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end
endmodule : rcm_top

// ==== sim/rcm_top_chk.sv ====
// Checker for rcm_top: AXI answers, compare reset values, irq quiet time.
// Assumes the bench never runs a read and a write at once.
`timescale 1ns/1ps
module rcm_top_chk
   import rcm_pkg::*;
#(
   parameter int HF_DIV = 40,  // Same as the design
   parameter int LF_DIV = 1221 // Same as the design
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        irq
);
   logic       cmp_wr_reg;                                  // Compare written since reset
   logic       en_wr_reg;                                   // Enable addressed since reset
   logic [7:0] aw_reg;                                      // Last write address
   logic [7:0] ar_reg;                                      // Last read address
   wire        aw_take = s_axi_awvalid && s_axi_awready;   // Write address taken
   wire        ar_take = s_axi_arvalid && s_axi_arready;   // Read address taken
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Address history; reset restores the power-up view
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_wr_reg <= 1'b0;
         en_wr_reg  <= 1'b0;
         aw_reg     <= 8'h00;
         ar_reg     <= 8'h00;
      end else begin
         if (aw_take) aw_reg <= s_axi_awaddr;
         if (ar_take) ar_reg <= s_axi_araddr;
         if (aw_take && s_axi_awaddr == OFF_CMP) cmp_wr_reg <= 1'b1;
         if (aw_take && s_axi_awaddr == OFF_IRQ_EN) en_wr_reg <= 1'b1;
      end
   end
   bresp_held_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response changed before bready");
   rdata_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before rready");
   read_latency_a: assert property (ar_take |-> ##[1:16] s_axi_rvalid)
      else $error("read answer missing");
   pending_reset_a: assert property (
      s_axi_rvalid && ar_reg == OFF_CMP && !cmp_wr_reg |-> s_axi_rdata[19:0] == CMP_RESET)
      else $error("pending compare not at full count");
   active_reset_a: assert property (
      s_axi_rvalid && ar_reg == OFF_ACTIVE && !cmp_wr_reg |-> s_axi_rdata[19:0] == CMP_RESET)
      else $error("active compare not at full count");
   mapped_okay_a: assert property (s_axi_rvalid && ar_reg <= OFF_ACTIVE && ar_reg[1:0] == 2'b00
      && ar_reg != OFF_IRQ_CLR |-> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
   cmp_write_a: assert property (s_axi_bvalid && aw_reg == OFF_CMP |-> s_axi_bresp == RESP_OKAY)
      else $error("compare write refused");
   irq_quiet_a: assert property (!en_wr_reg |-> !irq)
      else $error("irq without any enable");
endmodule : rcm_top_chk
bind rcm_top rcm_top_chk #(.HF_DIV(HF_DIV), .LF_DIV(LF_DIV)) i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ==== sim/rcm_ref_src.sv ====
// Precise reference pulse source at the reference input pin.
// Assumes the bench fires it only once the block reports ready.
`timescale 1ns/1ps
module rcm_ref_src (
   input  wire logic        aclk,
   input  wire logic        fire,
   input  wire logic [15:0] width,
   output logic             reference_pulse_in
);
   int left = 0; // High cycles still to go
   initial reference_pulse_in = 1'b0;
   // High time is the window width; idles low between pulses
   always @(posedge aclk) begin
      if (fire) left = width;
      else if (left != 0) left = left - 1;
      reference_pulse_in <= (left != 0);
   end
endmodule : rcm_ref_src

// ==== sim/test_rcm_top.sv ====
// Testbench for rcm_top: AXI4-Lite register tasks and measurement tests.
// Assumes short source dividers so one second lasts a few hundred cycles.
`timescale 1ns/1ps
module test_rcm_top;
   import rcm_pkg::*;
   localparam int HF = 4; // aclk cycles per fast source clock
   localparam int LF = 8; // aclk cycles per slow source clock
   logic        aclk = 1'b0, aresetn = 1'b0;                   // Clock, reset
   logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;              // Addresses
   logic [31:0] w_data = 32'h0, r_data, d, s0;                 // Data
   logic [3:0]  w_strb = 4'h0;                                 // Byte strobes
   logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0; // Write side
   logic        ar_valid = 1'b0, r_ready = 1'b0, fire = 1'b0;  // Read side, pulse start
   logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, irq, ref_pin; // Outputs
   logic [1:0]  b_resp, r_resp, resp;                          // Responses
   int          cyc = 0, compares = 0, miscompares = 0, t0, t1;  // Counters
   rcm_top #(.HF_DIV(HF), .LF_DIV(LF)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
      .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
      .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
      .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
      .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
      .reference_pulse_in(ref_pin), .irq(irq));
   rcm_ref_src i_ref (.aclk(aclk), .fire(fire), .width(16'd600), .reference_pulse_in(ref_pin));
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   // Write one word; each channel held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
      @(posedge aclk);
      aw_addr  <= a;
      w_data   <= v;
      w_strb   <= s;
      aw_valid <= 1'b1;
      w_valid  <= 1'b1;
      b_ready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw_ready) aw_valid <= 1'b0;
         if (w_ready) w_valid <= 1'b0;
      end while (b_valid !== 1'b1);
      b_ready <= 1'b0;
      resp = b_resp;
   endtask : wr
   // Read one word; rready raised only after the answer is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge aclk);
      ar_addr  <= a;
      ar_valid <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar_ready) ar_valid <= 1'b0;
      end while (r_valid !== 1'b1);
      // Late rready makes the design hold its answer a cycle
      r_ready <= 1'b1;
      @(posedge aclk);
      r_ready <= 1'b0;
      v = r_data;
      resp = r_resp;
   endtask : rd
   // Compare within a tolerance; zero tolerance for exact values
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
      compares++;
      if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      check(v, exp, 0);
   endtask : rd_chk
   // Poll a status bit; the watchdog bounds the wait
   task automatic wait_bit(input int b, input logic v);
      logic [31:0] s;
      do rd(OFF_STATUS, s); while (s[b] !== v);
   endtask : wait_bit
   task automatic wait_irq(output int t);
      // Look one edge on, so a flag cleared at this edge is not taken as new
      do @(posedge aclk); while (irq !== 1'b1);
      t = cyc;
   endtask : wait_irq
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   // Watchdog: the tests need about 16500 cycles
   initial begin
      repeat (40000) @(posedge aclk);
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(OFF_CMP, 32'h000fffff);
      rd_chk(OFF_ACTIVE, 32'h000fffff);
      // Stopped: writes land at once, byte by byte
      wr(OFF_CMP, 32'h00012345);
      rd_chk(OFF_ACTIVE, 32'h00012345);
      wr(OFF_CMP, 32'h000000aa, 4'h1);
      wr(OFF_CMP, 32'h00000f00, 4'h2);
      rd_chk(OFF_ACTIVE, 32'h00010faa);
      rd(8'h3c, d);
      check({30'h0, resp}, {30'h0, RESP_SLVERR}, 0); // Unmapped read refused
      $display("test stopped writes done");
      // Running: a new value waits for the next match
      wr(OFF_CMP, 32'd200);
      wr(OFF_IRQ_EN, 32'h1 << EV_SECOND);
      wr(OFF_CTRL1, 32'h5);
      wait_irq(t0);
      wr(OFF_CMP, 32'd100);
      rd_chk(OFF_ACTIVE, 32'd200);
      rd_chk(OFF_IRQ_ST, 32'h1 << EV_SECOND);
      wr(OFF_IRQ_CLR, 32'h1 << EV_SECOND);
      repeat (2) @(posedge aclk);
      check({31'h0, irq}, 32'h0, 0);                 // Cleared
      wait_irq(t0);
      rd_chk(OFF_ACTIVE, 32'd100);
      wr(OFF_IRQ_CLR, 32'h1 << EV_SECOND);
      wait_irq(t1);
      check(32'(t1 - t0), 100 * HF, HF);
      wr(OFF_CTRL1, 32'h4);
      wr(OFF_IRQ_EN, 32'h0);
      repeat (2) @(posedge aclk);
      check({31'h0, irq}, 32'h0, 0);                 // Masked
      wr(OFF_IRQ_CLR, 32'h7);
      rd_chk(OFF_IRQ_ST, 32'h0);
      $display("test second match done");
      // Counter 1 counts fast clocks while the pin pulse is high
      wait_bit(S_RUN1, 1'b0);
      wr(OFF_CTRL2, 32'h20);
      wr(OFF_CTRL1, 32'h7);
      wait_bit(S_RDY1, 1'b1);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (620) @(posedge aclk);
      wait_bit(S_RUN1, 1'b0);
      wr(OFF_CTRL1, 32'h4);
      rd(OFF_MON1, d);
      check(d, 600 / HF, 2);
      wr(OFF_CMP, d);
      rd_chk(OFF_ACTIVE, d);
      $display("test pin measurement done");
      // Counter 2 timed by sixteen counter 1 seconds of 200 fast clocks
      wr(OFF_CMP, 32'd200);
      wr(OFF_CTRL2, 32'h24);
      wr(OFF_CTRL2, 32'h1f);
      wait_bit(S_RDY2, 1'b1);
      rd(OFF_SECONDS, s0);
      wr(OFF_CTRL1, 32'h5);
      repeat (2000) @(posedge aclk);
      wait_bit(S_RUN2, 1'b0);
      rd(OFF_SECONDS, d);
      check({24'h0, d[7:0] - s0[7:0]}, 32'd17, 0);
      wr(OFF_CTRL2, 32'h04);
      rd(OFF_MON2, d);
      check(d, 16 * 200 * HF / LF, 2);
      $display("test tick measurement done");
      wrap_up();
   end
endmodule : test_rcm_top
